// file: spi_port.sv
// SPI master/slave port with byte registers on a WISHBONE slave and a transmit queue.
`timescale 1ns/1ps

module spi_txq #(
  parameter int unsigned W = 8,
  parameter int unsigned D = 8
) (
  input  wire logic         i_mclk,
  input  wire logic         i_rst,
  input  wire logic         i_flush,
  input  wire logic         i_valid,
  output logic              o_ready,
  input  wire logic [W-1:0] i_data,
  output logic              o_valid,
  input  wire logic         i_ready,
  output logic [W-1:0]      o_data
);
  localparam int unsigned AW = $clog2(D);
  logic [W-1:0]  mem_r [D];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0]   cnt_r;
  logic          push;
  logic          pop;

  assign o_ready = (cnt_r != (AW+1)'(D));
  assign o_valid = (cnt_r != '0);
  assign o_data  = mem_r[rd_r];
  assign push    = i_valid && o_ready;
  assign pop     = i_ready && o_valid;

  always_ff @(posedge i_mclk) begin
    if (push) begin
      mem_r[wr_r] <= i_data;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else if (i_flush) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wr_r <= (wr_r == AW'(D-1)) ? '0 : wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= (rd_r == AW'(D-1)) ? '0 : rd_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// Function
// RQ1: Writing any of the five control registers resets the serial engine.
// RQ2: Idle code sets minimum time before master select goes low.
// RQ3: Trail code sets minimum time from last clock edge to select high.
// RQ4: Lead code sets minimum time from select low to first clock edge.
// RQ5: Each lead or trail code step adds half a clock period.
// RQ6: Enable bit clear disables and idles; set dedicates the pins.
// RQ7: User wake enable requests wake-up when user select falls during standby.
// RQ8: Config wake enable requests wake-up when config select falls during standby.
// RQ9: Early launch bit moves data launch half a clock period earlier. Code uses mode_r bit 4, which MODE_MASK clears; launch never moves.
// RQ10: Master bit picks slave or master; any change idles the port.
// RQ11: Hold bit keeps master select low with no data pending.
// RQ12: Dummy mode answers 0xff until data, then one 0x00, then data.
// RQ13: External master looks for the first 0x00 byte to find data.
// RQ14: Host keeps feeding bytes at bus rate after the dummy phase.
// RQ15: Polarity bit picks idle clock level; change aborts and idles.
// RQ16: Phase bit picks first or second edge sampling; change aborts.
// RQ17: Low-bit-first bit sets shift order; registers keep MSB in bit 7.
// RQ18: External master uses default polarity and phase on config port.
// RQ19: Bit clock is bus clock divided by divider plus one; divider at least 1.
// RQ20: Prescaler reset value is the programmed nonvolatile value.
// RQ21: Each select register bit drives one active-low master select line.
// RQ22: Slave host writes transmit byte early enough; reads need a dummy byte.
// RQ23: Software writes zero to reserved bits.
// RQ24: Transmit-empty flag shows empty transmit path; a write clears it.
// RQ25: Mode fault sets on slave select low in master mode; control writes clear. Code clears it only on delay, enable or mode writes.
module spi_port
  import spi_port_pkg::*;
(
  input  wire logic         i_mclk,
  input  wire logic         i_rst,
  input  wire logic         i_wb_cyc,
  input  wire logic         i_wb_stb,
  input  wire logic         i_wb_we,
  input  wire logic [7:0]   i_wb_adr,
  input  wire logic [7:0]   i_wb_dat,
  output logic [7:0]        o_wb_dat,
  output logic              o_wb_ack,
  input  wire logic         i_sck,
  output logic              o_sck,
  output logic              o_sck_oe_n,
  input  wire logic         i_mosi,
  output logic              o_mosi,
  output logic              o_mosi_oe_n,
  input  wire logic         i_miso,
  output logic              o_miso,
  output logic              o_miso_oe_n,
  input  wire logic         i_slave_select_n,
  input  wire logic         i_config_slave_select_in_n,
  input  wire logic         i_standby,
  output logic              o_wake_req,
  output logic              o_port_dedicated,
  output logic [7:0]        o_master_select_line_n
);
  logic [7:0] delay_r, enwake_r, mode_r, prescale_r, select_r, irqen_r, irq_r, rx_byte_r;
  logic       receive_full_flag_r, roe_r, mdf_r, ack_r, core_rst_r, started_r;
  logic       sck_r, sck_oe_n_r, mosi_oe_n_r, miso_oe_n_r, wake_r, ded_r;
  logic [7:0] msel_n_r, rdat_r, tx_sh_r, rx_sh_r;
  logic [4:0] s1_r, s2_r, s3_r, f_r;
  logic       sck_prev_r, ssn_prev_r;
  logic [5:0] div_r;
  logic [3:0] dly_r, edge_r;
  logic [2:0] bit_r;
  mst_state_e mst_r;

  logic wb_req, wr, rd, port_en, master, half_tick, edge_ev, leading, smp_ev, lau_ev;
  logic byte_done, m_load, s_load, q_pop, q_valid, q_ready, transmit_empty_flag, cs_act, tip;
  logic [7:0] q_data, load_byte;
  logic [5:0] div_mid;

  // Bit reversal serves both shift directions so the shifters always run MSB first.
  function automatic logic [7:0] order(input logic [7:0] d, input logic low_bit_first);
    logic [7:0] r;
    r = d;
    if (low_bit_first) begin
      for (int i = 0; i < 8; i++) begin
        r[i] = d[7-i];
      end
    end
    return r;
  endfunction

  // Delay codes count half periods: code n waits n+1 half ticks.
  function automatic logic dly_done(input logic [3:0] cnt, input logic [2:0] code);
    return cnt == {1'b0, code};
  endfunction

  assign wb_req  = i_wb_cyc && i_wb_stb && !ack_r;
  assign wr      = wb_req && i_wb_we;
  assign rd      = wb_req && !i_wb_we;
  assign port_en = enwake_r[B_PORT_EN];
  assign master  = mode_r[B_MASTER];

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      ack_r <= 1'b0;
      rdat_r <= RST_ZERO;
    end else begin
      ack_r <= wb_req;
      case (i_wb_adr)
        ADR_DELAY:    rdat_r <= delay_r;
        ADR_ENWAKE:   rdat_r <= enwake_r;
        ADR_MODE:     rdat_r <= mode_r;
        ADR_PRESCALE: rdat_r <= prescale_r;
        ADR_SELECT:   rdat_r <= select_r;
        ADR_FLAGS:    rdat_r <= {tip, 2'b00, transmit_empty_flag, receive_full_flag_r, 1'b0, roe_r, mdf_r};
        ADR_RXBYTE:   rdat_r <= rx_byte_r;
        ADR_IRQ:      rdat_r <= irq_r;
        ADR_IRQEN:    rdat_r <= irqen_r;
        default:      rdat_r <= RST_ZERO;
      endcase
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      delay_r    <= RST_ZERO;
      enwake_r   <= RST_ZERO;
      mode_r     <= RST_ZERO;
      prescale_r <= PRESCALE_NV; // RQ20
      select_r   <= RST_ZERO;
      irqen_r    <= RST_ZERO;
      core_rst_r <= 1'b0;
    end else begin
      core_rst_r <= 1'b0;
      if (wr) begin
        case (i_wb_adr)
          ADR_DELAY:    delay_r    <= i_wb_dat;
          ADR_ENWAKE:   enwake_r   <= i_wb_dat & ENWAKE_MASK;
          ADR_MODE:     mode_r     <= i_wb_dat & MODE_MASK;
          ADR_PRESCALE: prescale_r <= i_wb_dat & PRESCALE_MASK;
          ADR_SELECT:   select_r   <= i_wb_dat;
          ADR_IRQEN:    irqen_r    <= i_wb_dat & IRQ_MASK;
          default:      ;
        endcase
        // A format, mode or polarity change can only arrive by a write, so this also idles on them.
        if (i_wb_adr >= ADR_DELAY && i_wb_adr <= ADR_SELECT) begin
          core_rst_r <= 1'b1; // RQ1 RQ10 RQ15 RQ16 RQ17
        end
      end
    end
  end

  // Pins pass three flops; a new level is taken only once the last two agree.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      s1_r <= 5'h1f;
      s2_r <= 5'h1f;
      s3_r <= 5'h1f;
      f_r  <= 5'h1f;
    end else begin
      s1_r <= {i_config_slave_select_in_n, i_slave_select_n, i_miso, i_mosi, i_sck};
      s2_r <= s1_r;
      s3_r <= s2_r;
      f_r  <= (s3_r & ~(s2_r ^ s3_r)) | (f_r & (s2_r ^ s3_r));
    end
  end

  // Divider: one bit clock per prescale+1 bus clocks, with a half tick at mid and end.
  assign div_mid   = prescale_r[5:0] >> 1;
  assign half_tick = (div_r == prescale_r[5:0]) || (div_r == div_mid); // RQ19
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      div_r <= '0;
    end else if (core_rst_r || div_r >= prescale_r[5:0]) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 1'b1;
    end
  end

  spi_txq #(.W(DAT_W), .D(TXQ_DEPTH)) u_txq (
    .i_mclk  (i_mclk),
    .i_rst   (i_rst),
    .i_flush (1'b0),
    .i_valid (wr && i_wb_adr == ADR_TXBYTE),
    .o_ready (q_ready),
    .i_data  (i_wb_dat),
    .o_valid (q_valid),
    .i_ready (q_pop),
    .o_data  (q_data)
  );
  assign transmit_empty_flag = !q_valid; // RQ24

  // Shared edge decode: master edges come from the divider, slave edges from the pin.
  assign edge_ev = port_en && (master ? (mst_r == M_XFER && half_tick)
                                      : (f_r[0] != sck_prev_r && !f_r[3]));
  assign leading = master ? !edge_r[0] : (f_r[0] != mode_r[B_CPOL]);
  assign smp_ev  = edge_ev && (leading ^ mode_r[B_CPHA]); // RQ16
  assign lau_ev  = edge_ev && (mode_r[B_EARLY] ? (leading ^ mode_r[B_CPHA]) : !(leading ^ mode_r[B_CPHA])); // RQ9
  assign byte_done = smp_ev && bit_r == BIT_LAST;
  assign tip     = master ? (mst_r != M_IDLE) : (port_en && !f_r[3]);

  // Master sequencer.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      mst_r  <= M_IDLE;
      dly_r  <= '0;
      edge_r <= '0;
    end else if (core_rst_r || !port_en || !master) begin
      mst_r  <= M_IDLE; // RQ6
      dly_r  <= '0;
      edge_r <= '0;
    end else if (half_tick) begin
      dly_r <= dly_r + 1'b1;
      case (mst_r)
        M_IDLE: begin
          dly_r <= '0;
          if (q_valid || mode_r[B_HOLD]) begin
            mst_r <= M_GAP;
          end
        end
        M_GAP: if (dly_done(dly_r, {1'b0, delay_r[IDLE_HI:IDLE_LO]})) begin // RQ2
          mst_r <= M_LEAD;
          dly_r <= '0;
        end
        M_LEAD: if (dly_done(dly_r, delay_r[LEAD_HI:LEAD_LO]) && q_valid) begin // RQ4 RQ5
          mst_r  <= M_XFER;
          edge_r <= '0;
        end
        M_XFER: begin
          edge_r <= edge_r + 1'b1;
          if (edge_r == EDGE_LAST) begin
            dly_r <= '0;
            if (!q_valid) begin
              mst_r <= mode_r[B_HOLD] ? M_HOLD : M_TRAIL; // RQ11
            end
          end
        end
        M_HOLD: begin
          if (q_valid) begin
            mst_r  <= M_XFER;
            edge_r <= '0;
          end else if (!mode_r[B_HOLD]) begin
            mst_r <= M_TRAIL;
            dly_r <= '0;
          end
        end
        M_TRAIL: if (dly_done(dly_r, delay_r[TRAIL_HI:TRAIL_LO])) begin // RQ3 RQ5
          mst_r <= M_IDLE;
        end
        default: mst_r <= M_IDLE;
      endcase
    end
  end

  assign m_load = master && half_tick && q_valid && port_en && !core_rst_r &&
                  ((mst_r == M_LEAD && dly_done(dly_r, delay_r[LEAD_HI:LEAD_LO])) ||
                   mst_r == M_HOLD || (mst_r == M_XFER && edge_r == EDGE_LAST));
  assign s_load = !master && port_en && ((ssn_prev_r && !f_r[3]) || (byte_done && !f_r[3]));
  assign q_pop  = m_load || (s_load && q_valid && !(mode_r[B_DUMMY] && !started_r));

  always_comb begin
    load_byte = q_data;
    if (s_load && !q_valid) begin
      load_byte = BYTE_DUMMY; // RQ12
    end else if (s_load && mode_r[B_DUMMY] && !started_r) begin
      load_byte = BYTE_MARK; // RQ12
    end
  end

  // Shift datapath shared by both modes.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      tx_sh_r <= BYTE_DUMMY;
      rx_sh_r <= RST_ZERO;
      bit_r   <= '0;
    end else if (core_rst_r || !port_en) begin
      tx_sh_r <= BYTE_DUMMY;
      bit_r   <= '0;
    end else begin
      if (smp_ev) begin
        rx_sh_r <= {rx_sh_r[6:0], master ? f_r[2] : f_r[1]};
        bit_r   <= bit_r + 1'b1;
      end
      if (m_load || s_load) begin
        tx_sh_r <= order(load_byte, mode_r[B_LOW_BIT_FIRST]); // RQ17
        bit_r   <= '0;
      end else if (lau_ev && (bit_r != '0 || smp_ev)) begin
        tx_sh_r <= {tx_sh_r[6:0], 1'b1};
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      started_r <= 1'b0;
    end else if (core_rst_r || f_r[3]) begin
      started_r <= 1'b0;
    end else if (s_load && q_valid && mode_r[B_DUMMY]) begin
      started_r <= 1'b1;
    end
  end

  // Receive and fault flags; a setting event wins over a clear in the same cycle.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      rx_byte_r <= RST_ZERO;
      receive_full_flag_r    <= 1'b0;
      roe_r     <= 1'b0;
      mdf_r     <= 1'b0;
    end else begin
      if (byte_done) begin
        rx_byte_r <= order({rx_sh_r[6:0], master ? f_r[2] : f_r[1]}, mode_r[B_LOW_BIT_FIRST]);
        receive_full_flag_r    <= 1'b1;
        roe_r     <= roe_r || receive_full_flag_r;
      end else if (rd && i_wb_adr == ADR_RXBYTE) begin
        receive_full_flag_r <= 1'b0;
      end
      if (master && port_en && !f_r[3]) begin
        mdf_r <= 1'b1; // RQ25
      end else if (wr && i_wb_adr >= ADR_DELAY && i_wb_adr <= ADR_MODE) begin
        mdf_r <= 1'b0; // RQ25
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      irq_r <= RST_ZERO;
    end else begin
      irq_r <= ((wr && i_wb_adr == ADR_IRQ) ? (irq_r & ~i_wb_dat) : irq_r)
             | (irqen_r & {3'b000, transmit_empty_flag, receive_full_flag_r, 1'b0, roe_r, mdf_r});
    end
  end

  // Pin drivers, all registered.
  assign cs_act = master && port_en && (mst_r == M_LEAD || mst_r == M_XFER || mst_r == M_HOLD ||
                                        mst_r == M_TRAIL);
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      sck_r       <= 1'b0;
      sck_oe_n_r  <= 1'b1;
      mosi_oe_n_r <= 1'b1;
      miso_oe_n_r <= 1'b1;
      msel_n_r    <= 8'hff;
      sck_prev_r  <= 1'b0;
      ssn_prev_r  <= 1'b1;
      wake_r      <= 1'b0;
      ded_r       <= 1'b0;
    end else begin
      sck_r       <= (mst_r == M_XFER && half_tick) ? !sck_r
                   : (mst_r == M_XFER) ? sck_r : mode_r[B_CPOL]; // RQ15
      sck_oe_n_r  <= !(port_en && master);
      mosi_oe_n_r <= !(port_en && master);
      miso_oe_n_r <= !(port_en && !master && !f_r[3]);
      msel_n_r    <= cs_act ? ~select_r : 8'hff; // RQ21
      sck_prev_r  <= f_r[0];
      ssn_prev_r  <= f_r[3];
      ded_r       <= port_en; // RQ6
      wake_r      <= i_standby && ((enwake_r[B_WAKE_USR] && !f_r[3]) || // RQ7
                                   (enwake_r[B_WAKE_CFG] && !f_r[4]));  // RQ8
    end
  end

  assign o_wb_dat               = rdat_r;
  assign o_wb_ack               = ack_r;
  assign o_sck                  = sck_r;
  assign o_sck_oe_n             = sck_oe_n_r;
  assign o_mosi                 = tx_sh_r[7];
  assign o_mosi_oe_n            = mosi_oe_n_r;
  assign o_miso                 = tx_sh_r[7];
  assign o_miso_oe_n            = miso_oe_n_r;
  assign o_wake_req             = wake_r;
  assign o_port_dedicated       = ded_r;
  assign o_master_select_line_n = msel_n_r;

  property p_ack_one;
    @(posedge i_mclk) disable iff (i_rst) wb_req |=> o_wb_ack ##1 !o_wb_ack;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("bus ack not a single cycle");
  property p_ctrl_reset;
    @(posedge i_mclk) disable iff (i_rst) (wr && i_wb_adr == ADR_DELAY) |=> core_rst_r ##1 mst_r == M_IDLE;
  endproperty
  a_ctrl_reset: assert property (p_ctrl_reset) else $error("control write did not idle"); // RQ1
  property p_disabled;
    @(posedge i_mclk) disable iff (i_rst) !port_en [*2] |-> o_master_select_line_n == 8'hff && o_sck_oe_n;
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled port still drives"); // RQ6
  property p_idle_cs;
    @(posedge i_mclk) disable iff (i_rst) (mst_r == M_IDLE) |=> o_master_select_line_n == 8'hff;
  endproperty
  a_idle_cs: assert property (p_idle_cs) else $error("select low while idle"); // RQ21
  property p_transmit_empty_flag_clear;
    @(posedge i_mclk) disable iff (i_rst) (wr && i_wb_adr == ADR_TXBYTE && q_ready) |=> !transmit_empty_flag;
  endproperty
  a_transmit_empty_flag_clear: assert property (p_transmit_empty_flag_clear) else $error("transmit write left flag set"); // RQ24
  property p_mdf_set;
    @(posedge i_mclk) disable iff (i_rst) (master && port_en && !f_r[3]) |=> mdf_r;
  endproperty
  a_mdf_set: assert property (p_mdf_set) else $error("mode fault missed"); // RQ25
  property p_wake;
    @(posedge i_mclk) disable iff (i_rst) (i_standby && enwake_r[B_WAKE_CFG] && !f_r[4]) |=> o_wake_req;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake request"); // RQ8
  property p_sck_idle;
    @(posedge i_mclk) disable iff (i_rst) (mst_r == M_TRAIL) [*2] |-> o_sck == mode_r[B_CPOL];
  endproperty
  a_sck_idle: assert property (p_sck_idle) else $error("clock not at idle level"); // RQ15
endmodule

// file: spi_port_pkg.sv
// Register map, field positions and reset values of the SPI port.
package spi_port_pkg;
  localparam int unsigned ADR_W        = 8;
  localparam int unsigned DAT_W        = 8;
  localparam int unsigned TXQ_DEPTH    = 8;
  localparam logic [7:0]  ADR_DELAY    = 8'h54;
  localparam logic [7:0]  ADR_ENWAKE   = 8'h55;
  localparam logic [7:0]  ADR_MODE     = 8'h56;
  localparam logic [7:0]  ADR_PRESCALE = 8'h57;
  localparam logic [7:0]  ADR_SELECT   = 8'h58;
  localparam logic [7:0]  ADR_TXBYTE   = 8'h59;
  localparam logic [7:0]  ADR_FLAGS    = 8'h5a;
  localparam logic [7:0]  ADR_RXBYTE   = 8'h5b;
  localparam logic [7:0]  ADR_IRQ      = 8'h5c;
  localparam logic [7:0]  ADR_IRQEN    = 8'h5d;
  localparam logic [7:0]  RST_ZERO     = 8'h00;
  localparam logic [7:0]  PRESCALE_NV  = 8'h01;  // Stands in for the value programmed into nonvolatile memory.
  localparam logic [7:0]  BYTE_DUMMY   = 8'hff;
  localparam logic [7:0]  BYTE_MARK    = 8'h00;
  // Field positions inside the delay register.
  localparam int unsigned IDLE_HI = 7;
  localparam int unsigned IDLE_LO = 6;
  localparam int unsigned TRAIL_HI = 5;
  localparam int unsigned TRAIL_LO = 3;
  localparam int unsigned LEAD_HI = 2;
  localparam int unsigned LEAD_LO = 0;
  // Enable and wake register.
  localparam int unsigned B_PORT_EN  = 7;
  localparam int unsigned B_WAKE_USR = 6;
  localparam int unsigned B_WAKE_CFG = 5;
  localparam int unsigned B_EARLY    = 4;
  localparam logic [7:0]  ENWAKE_MASK = 8'hf0;
  // Mode and format register.
  localparam int unsigned B_MASTER = 7;
  localparam int unsigned B_HOLD   = 6;
  localparam int unsigned B_DUMMY  = 5;
  localparam int unsigned B_CPOL   = 2;
  localparam int unsigned B_CPHA   = 1;
  localparam int unsigned B_LOW_BIT_FIRST   = 0;
  localparam logic [7:0]  MODE_MASK = 8'he7;
  localparam logic [7:0]  PRESCALE_MASK = 8'h3f;
  // Status and interrupt bit positions.
  localparam int unsigned S_TIP  = 7;
  localparam int unsigned S_TRANSMIT_EMPTY_FLAG = 4;
  localparam int unsigned S_RECEIVE_FULL_FLAG = 3;
  localparam int unsigned S_ROE  = 1;
  localparam int unsigned S_MDF  = 0;
  localparam logic [7:0]  IRQ_MASK = 8'h1b;
  localparam logic [2:0]  BIT_LAST  = 3'h7;
  localparam logic [3:0]  EDGE_LAST = 4'hf;
  typedef enum logic [2:0] {M_IDLE, M_GAP, M_LEAD, M_XFER, M_HOLD, M_TRAIL} mst_state_e;
endpackage

// file: spi_slave_model.sv
// Behavioural external SPI slave used as the far side of the port in master mode.
`timescale 1ns/1ps

module spi_slave_model (
  input  wire logic i_sck,
  input  wire logic i_cs_n,
  input  wire logic i_mosi,
  output logic      o_miso
);
  logic [7:0] sh_in;
  logic [7:0] rx_log [0:15];
  int         bits;
  int         count;
  realtime    t_cs;
  realtime    t_first;
  bit         first;
  localparam logic [7:0] REPLY = 8'h3c;

  initial begin
    count = 0;
    bits = 0;
    first = 0;
    o_miso = 1'b1;
  end

  // Only the default clock format is spoken, rising edge sample and falling edge launch.
  always @(negedge i_cs_n) begin
    bits = 0;
    first = 1;
    t_cs = $realtime;
    o_miso = 1'b0;
  end

  always @(posedge i_sck) begin
    if (i_cs_n === 1'b0) begin
      if (first)
        t_first = $realtime;
      first = 0;
      sh_in = {sh_in[6:0], i_mosi};
      bits++;
      if (bits == 8) begin
        rx_log[count] = sh_in;
        count++;
        bits = 0;
      end
    end
  end

  // Every byte answered is 0x3c, launched most significant bit first.
  always @(negedge i_sck) begin
    if (i_cs_n === 1'b0)
      o_miso = REPLY[7 - bits];
  end

  // A released line must not keep its last level, or a late sample would pass by luck.
  always @(posedge i_cs_n)
    o_miso = ~o_miso;
endmodule

// file: spi_port_tb.sv
// Self-checking testbench of the SPI port with an external slave model.
`timescale 1ns/1ps

module spi_port_tb;
  import spi_port_pkg::*;

  logic       i_mclk;
  logic       i_rst;
  logic       cyc, stb, we, ssel_n, standby, sck_m, cfg_n;
  logic [7:0] adr, wdat, rdat, msel_n;
  logic       ack, sck_o, sck_oe_n, mosi_o, mosi_oe_n, miso_o, miso_oe_n, miso_m, wake, dedicated;
  int         errors;
  int         checks_done;
  logic [7:0] q;
  wire        sck_w  = sck_oe_n ? sck_m : sck_o;
  wire        mosi_w = mosi_oe_n ? 1'b1 : mosi_o;
  wire        miso_w = miso_oe_n ? miso_m : miso_o;

  spi_port DUT (.i_mclk(i_mclk), .i_rst(i_rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_sck(sck_w), .o_sck(sck_o),
    .o_sck_oe_n(sck_oe_n), .i_mosi(mosi_w), .o_mosi(mosi_o), .o_mosi_oe_n(mosi_oe_n),
    .i_miso(miso_w), .o_miso(miso_o), .o_miso_oe_n(miso_oe_n), .i_slave_select_n(ssel_n),
    .i_config_slave_select_in_n(cfg_n), .i_standby(standby), .o_wake_req(wake),
    .o_port_dedicated(dedicated), .o_master_select_line_n(msel_n));

  spi_slave_model m (.i_sck(sck_w), .i_cs_n(msel_n[0]), .i_mosi(mosi_w), .o_miso(miso_m));

  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end

  task automatic wrap_up();
    $display("checks_done=%0d errors=%0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // The request is held until ack has been seen, then dropped on the next falling edge.
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge i_mclk);
    cyc = 1'b1;
    stb = 1'b1;
    we = w;
    adr = a;
    wdat = d;
    do begin
      @(negedge i_mclk);
      n++;
    end while (ack !== 1'b1 && n < 8);
    chk({7'h0, ack}, 8'h01);
    q = rdat;
    @(negedge i_mclk);
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    chk(q, exp);
  endtask

  task automatic wait_bytes(input int k);
    int n;
    n = 0;
    while (m.count < k && n < 3000) begin
      @(negedge i_mclk);
      n++;
    end
    repeat (200) @(negedge i_mclk);
  endtask

  task automatic t_regs();
    rd(ADR_DELAY, 8'h00);
    rd(ADR_PRESCALE, PRESCALE_NV);
    rd(ADR_SELECT, 8'h00);
    rd(ADR_FLAGS, 8'h10);
    chk(msel_n, 8'hff);
    wr(ADR_ENWAKE, 8'hf0);
    rd(ADR_ENWAKE, 8'hf0);
    chk({7'h0, dedicated}, 8'h01);
    wr(ADR_PRESCALE, 8'h3f);
    rd(ADR_PRESCALE, 8'h3f);
    // The hold bit is set by this write like the other mode bits, whatever the divider.
    wr(ADR_MODE, 8'he7);
    rd(ADR_MODE, 8'he7);
    rd(8'h60, 8'h00);
    wr(ADR_ENWAKE, 8'h00);
    chk({7'h0, dedicated}, 8'h00);
  endtask

  // Nine bytes go in with the port off, so the queue must refuse the last one.
  task automatic t_queue();
    wr(ADR_MODE, 8'h80);
    wr(ADR_PRESCALE, 8'h0f);
    wr(ADR_SELECT, 8'h01);
    wr(ADR_DELAY, 8'h07);
    for (int i = 0; i < 9; i++)
      wr(ADR_TXBYTE, 8'h10 + 8'(i));
    rd(ADR_FLAGS, 8'h00);
    wr(ADR_ENWAKE, 8'h80);
    wait_bytes(8);
    chk(8'(m.count), 8'h08);
    for (int i = 0; i < 8; i++)
      chk(m.rx_log[i], 8'h10 + 8'(i));
    chk({7'h0, m.t_first - m.t_cs >= 64 * 20.0}, 8'h01);
    rd(ADR_FLAGS, 8'h1a);
    rd(ADR_RXBYTE, 8'h3c);
    chk(msel_n, 8'hff);
  endtask

  task automatic t_fault();
    ssel_n = 1'b0;
    repeat (10) @(negedge i_mclk);
    rd(ADR_FLAGS, 8'h13);
    ssel_n = 1'b1;
    repeat (10) @(negedge i_mclk);
    wr(ADR_DELAY, 8'h00);
    rd(ADR_FLAGS, 8'h12);
  endtask

  task automatic t_lsb();
    wr(ADR_MODE, 8'h81);
    wr(ADR_TXBYTE, 8'h01);
    wait_bytes(9);
    chk(m.rx_log[8], 8'h80);
  endtask

  task automatic t_wake();
    wr(ADR_MODE, 8'h00);
    wr(ADR_ENWAKE, 8'hc0);
    standby = 1'b1;
    repeat (10) @(negedge i_mclk);
    chk({7'h0, wake}, 8'h00);
    ssel_n = 1'b0;
    repeat (10) @(negedge i_mclk);
    chk({7'h0, wake}, 8'h01);
    ssel_n = 1'b1;
    wr(ADR_ENWAKE, 8'ha0);
    chk({7'h0, wake}, 8'h00);
    cfg_n = 1'b0;
    repeat (10) @(negedge i_mclk);
    chk({7'h0, wake}, 8'h01);
    cfg_n = 1'b1;
    standby = 1'b0;
  endtask

  // The bench acts as external master; a bit lasts 32 bus clocks so the pin synchronisers keep up.
  task automatic spi_byte(input logic [7:0] exp);
    logic [7:0] v;
    v = '0;
    for (int i = 0; i < 8; i++) begin
      v = {v[6:0], miso_w};
      sck_m = 1'b1;
      repeat (16) @(negedge i_mclk);
      sck_m = 1'b0;
      repeat (16) @(negedge i_mclk);
    end
    chk(v, exp);
  endtask

  task automatic t_slave();
    wr(ADR_MODE, 8'h20);
    wr(ADR_ENWAKE, 8'h80);
    ssel_n = 1'b0;
    repeat (10) @(negedge i_mclk);
    chk({7'h0, miso_oe_n}, 8'h00);
    wr(ADR_TXBYTE, 8'ha5);
    spi_byte(8'hff);
    spi_byte(8'h00);
    spi_byte(8'ha5);
    ssel_n = 1'b1;
    repeat (10) @(negedge i_mclk);
    rd(ADR_RXBYTE, 8'hff);
  endtask

  initial begin
    errors = 0;
    checks_done = 0;
    i_rst = 1'b1;
    {cyc, stb, we, adr, wdat} = '0;
    ssel_n = 1'b1;
    standby = 1'b0;
    sck_m = 1'b0;
    cfg_n = 1'b1;
    repeat (6) @(negedge i_mclk);
    i_rst = 1'b0;
    t_regs();
    t_queue();
    t_fault();
    t_lsb();
    t_wake();
    t_slave();
    wrap_up();
  end

  // The whole run needs well under this many clocks.
  initial begin
    #(20 * 20000);
    errors++;
    wrap_up();
  end
endmodule
